// ### core/rtp_port.sv
// Eight-bit I/O port with realtime output shadow latches and APB slave.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
module rtp_port (
    // APB slave.
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [rtp_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Port pins, enable low while driving.
    input  wire logic [7:0]  port_pin_in,
    output logic      [7:0]  port_pin_out,
    output logic      [7:0]  port_pin_oe_n,
    // Trigger sources.
    input  wire logic        external_trigger_pin,
    input  wire logic        head_switch_timing_trigger,
    // Alternate input to the timer.
    output logic             timer_event_input
);
    localparam int W = rtp_pkg::PORT_W;

    logic [W-1:0] func_q;
    logic [W-1:0] dir_q;
    logic [W-1:0] data_q;
    logic [W-1:0] src_q;
    logic [W-1:0] dshadow_q;
    logic [W-1:0] cshadow_q;
    logic [1:0]   edge_q;
    logic [7:0]   aux_q;
    logic [2:0]   pmode_q;
    logic [2:0]   ext_sync_q;
    logic [2:0]   hsw_sync_q;
    logic [2:0]   pin_sync_q [W];
    logic [W-1:0] pin_level_q;
    logic         ext_prev_q;
    logic         hsw_prev_q;
    logic         ext_hit_q;
    logic         hsw_hit_q;

    // Bus decode.
    wire          acc      = psel & penable;
    wire          wr       = acc & pwrite;
    // Each register is one aligned word; unaligned addresses are unmapped.
    wire [15:0]   reg_idx  = paddr[rtp_pkg::ADDR_W-1:2];
    wire          aligned  = paddr[1:0] == 2'h0;
    wire          hit_data = aligned & (reg_idx == rtp_pkg::ADR_DATA);
    wire          hit_dir  = aligned & (reg_idx == rtp_pkg::ADR_DIR);
    wire          hit_aux  = aligned & (reg_idx == rtp_pkg::ADR_AUX_MODE);
    wire          hit_func = aligned & (reg_idx == rtp_pkg::ADR_FUNC);
    wire          hit_edge = aligned & (reg_idx == rtp_pkg::ADR_EDGE);
    wire          hit_src  = aligned & (reg_idx == rtp_pkg::ADR_SRC);
    wire          hit_pwr  = aligned & (reg_idx == rtp_pkg::ADR_POWER);
    wire          mapped   = hit_data | hit_dir | hit_aux | hit_func |
                             hit_edge | hit_src | hit_pwr;
    wire [W-1:0]  wbyte    = pwdata[W-1:0];
    wire          wr_data  = wr & hit_data;
    wire          wr_dir   = wr & hit_dir;

    // Synchronised trigger levels: stages two and three must agree.
    wire ext_lvl = ext_sync_q[2];
    wire hsw_lvl = hsw_sync_q[2];
    wire ext_stable = ext_sync_q[1] == ext_sync_q[2];
    wire hsw_stable = hsw_sync_q[1] == hsw_sync_q[2];
    wire ext_rise = ext_stable & ext_lvl & ~ext_prev_q;
    wire ext_fall = ext_stable & ~ext_lvl & ext_prev_q;
    wire hsw_rise = hsw_stable & hsw_lvl & ~hsw_prev_q;
    wire hsw_fall = hsw_stable & ~hsw_lvl & hsw_prev_q;
    // Edge qualification by the two-bit field.
    wire ext_evt = (edge_q[0] & ext_rise) | (edge_q[1] & ext_fall);
    wire hsw_evt = (edge_q[0] & hsw_rise) | (edge_q[1] & hsw_fall);
    // Per-bit trigger from the selected source.
    wire [W-1:0] trig_bits = ({W{ext_hit_q}} & ~src_q) |
                             ({W{hsw_hit_q}} &  src_q);
    wire [W-1:0] rt_load   = trig_bits & func_q;

    // Power modes: float, hold or run.
    wire pm_float = pmode_q == 3'(rtp_pkg::RTP_PM_STANDBY) ||
                    pmode_q == 3'(rtp_pkg::RTP_PM_WATCH);
    wire pm_hold  = pmode_q == 3'(rtp_pkg::RTP_PM_SLEEP) ||
                    pmode_q == 3'(rtp_pkg::RTP_PM_SUBSLEEP);

    // Shadow next values: general mode mirrors writes, realtime loads on
    // a trigger.
    logic [W-1:0] dshadow_d;
    logic [W-1:0] cshadow_d;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            dshadow_d[i] = dshadow_q[i];
            cshadow_d[i] = cshadow_q[i];
            if (!func_q[i]) begin
                if (wr_data) dshadow_d[i] = wbyte[i];
                if (wr_dir)  cshadow_d[i] = wbyte[i];
            end else if (rt_load[i]) begin
                dshadow_d[i] = data_q[i];
                cshadow_d[i] = dir_q[i];
            end
        end
    end

    // Pin drive per mode. Pin six has no converter case here, since the
    // converter picks its own trigger input.
    logic [W-1:0] drv_val;
    logic [W-1:0] drv_en;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (func_q[i]) begin
                drv_val[i] = dshadow_q[i];
                drv_en[i]  = cshadow_q[i];
            end else begin
                drv_val[i] = data_q[i];
                drv_en[i]  = dir_q[i];
            end
        end
        // The timer input function takes the top pin as an input whatever
        // its direction bit holds; only the read still follows that bit.
        if (aux_q[rtp_pkg::AUX_TMR_BIT]) begin
            drv_en[rtp_pkg::TMR_PIN] = 1'b0;
        end
    end

    // Data register read value per pin.
    logic [W-1:0] data_rd;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (func_q[i] &&
                !(i == rtp_pkg::TMR_PIN && aux_q[rtp_pkg::AUX_TMR_BIT]))
            begin
                data_rd[i] = data_q[i];
            end else begin
                data_rd[i] = dir_q[i] ? data_q[i] : pin_level_q[i];
            end
        end
    end

    wire [7:0] rd_mux =
        hit_data ? data_rd :
        hit_dir  ? rtp_pkg::DIR_READ_VALUE :
        hit_aux  ? aux_q :
        hit_func ? func_q :
        hit_edge ? (rtp_pkg::EDGE_FIXED_ONES | {6'h00, edge_q}) :
        hit_src  ? src_q :
        hit_pwr  ? {5'h00, pmode_q} : 8'h00;

    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;
    // The converter trigger on pin six is chosen by the converter itself.
    assign timer_event_input = pin_level_q[rtp_pkg::TMR_PIN];

    // Registers written by software.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_q  <= rtp_pkg::RST_ZERO;
            dir_q   <= rtp_pkg::RST_ZERO;
            data_q  <= rtp_pkg::RST_ZERO;
            src_q   <= rtp_pkg::RST_ZERO;
            edge_q  <= rtp_pkg::EDGE_OFF;
            aux_q   <= rtp_pkg::RST_AUX_MODE;
            pmode_q <= 3'(rtp_pkg::RTP_PM_ACTIVE);
        end else if (wr) begin
            if (hit_func) func_q <= wbyte;
            if (hit_dir)  dir_q  <= wbyte;
            if (hit_data) data_q <= wbyte;
            if (hit_src)  src_q  <= wbyte;
            if (hit_edge) edge_q <= wbyte[1:0];
            if (hit_aux)
                aux_q <= (wbyte & rtp_pkg::AUX_RW_MASK) |
                         (rtp_pkg::RST_AUX_MODE & ~rtp_pkg::AUX_RW_MASK);
            if (hit_pwr)  pmode_q <= wbyte[2:0];
        end
    end

    // Shadows and trigger pipeline.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dshadow_q  <= rtp_pkg::RST_ZERO;
            cshadow_q  <= rtp_pkg::RST_ZERO;
            ext_sync_q <= 3'h0;
            hsw_sync_q <= 3'h0;
            ext_prev_q <= 1'b0;
            hsw_prev_q <= 1'b0;
            ext_hit_q  <= 1'b0;
            hsw_hit_q  <= 1'b0;
        end else begin
            dshadow_q  <= dshadow_d;
            cshadow_q  <= cshadow_d;
            ext_sync_q <= {ext_sync_q[1:0], external_trigger_pin};
            hsw_sync_q <= {hsw_sync_q[1:0], head_switch_timing_trigger};
            if (ext_stable) ext_prev_q <= ext_lvl;
            if (hsw_stable) hsw_prev_q <= hsw_lvl;
            ext_hit_q  <= ext_evt;
            hsw_hit_q  <= hsw_evt;
        end
    end

    // Pin input synchronisers, one per pin.
    // One process for all pins keeps each register under a single driver.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < W; i++) begin
                pin_sync_q[i] <= 3'h0;
            end
            pin_level_q <= rtp_pkg::RST_ZERO;
        end else begin
            for (int i = 0; i < W; i++) begin
                pin_sync_q[i] <= {pin_sync_q[i][1:0], port_pin_in[i]};
                if (pin_sync_q[i][1] == pin_sync_q[i][2]) begin
                    pin_level_q[i] <= pin_sync_q[i][2];
                end
            end
        end
    end

    // Pin outputs: registered, frozen in sleep, floated when powered down.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_pin_out  <= 8'h00;
            port_pin_oe_n <= 8'hff;
        end else if (pm_float) begin
            port_pin_oe_n <= 8'hff;
        end else if (!pm_hold) begin
            port_pin_out  <= drv_val;
            port_pin_oe_n <= ~drv_en;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite) prdata <= {24'h000000, rd_mux};
    end

    // Checks.
    AST_RT_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
        func_q[0] && !pm_float && !pm_hold |=>
        port_pin_oe_n[0] == !$past(cshadow_q[0]))
        else $error("realtime pin drive enable wrong");
    AST_GP_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
        !func_q[1] && !pm_float && !pm_hold |=>
        port_pin_out[1] == $past(data_q[1]))
        else $error("general pin data wrong");
    AST_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        ext_hit_q && func_q[2] && !src_q[2] |=>
        dshadow_q[2] == $past(data_q[2]))
        else $error("shadow load missed");
    AST_MIRROR: assert property (@(posedge pclk) disable iff (!presetn)
        wr_dir && !func_q[3] |=> cshadow_q[3] == $past(wbyte[3]))
        else $error("direction shadow not mirrored");
    AST_EDGE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        edge_q == rtp_pkg::EDGE_OFF |=> !ext_hit_q && !hsw_hit_q)
        else $error("trigger seen while disabled");
    AST_SYNC_LAT: assert property (@(posedge pclk) disable iff (!presetn)
        edge_q == rtp_pkg::EDGE_RISE && ext_rise |=> ext_hit_q)
        else $error("trigger pulse latency wrong");
    AST_RD_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && hit_edge |=>
        prdata[7:2] == 6'h3f)
        else $error("edge register upper bits not one");
    AST_RD_DIR: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && hit_dir |=>
        prdata[7:0] == rtp_pkg::DIR_READ_VALUE)
        else $error("direction register read not ones");
    AST_FLOAT: assert property (@(posedge pclk) disable iff (!presetn)
        pm_float |=> port_pin_oe_n == 8'hff)
        else $error("pins driven in standby");
    AST_TMR_FLOAT: assert property (
        @(posedge pclk) disable iff (!presetn)
        aux_q[rtp_pkg::AUX_TMR_BIT] && !pm_hold |=>
        port_pin_oe_n[rtp_pkg::TMR_PIN])
        else $error("timer input pin driven");
    AST_TMR_READ: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && hit_data &&
        aux_q[rtp_pkg::AUX_TMR_BIT] && dir_q[rtp_pkg::TMR_PIN] |=>
        prdata[rtp_pkg::TMR_PIN] == $past(data_q[rtp_pkg::TMR_PIN]))
        else $error("timer pin read wrong");
    AST_HOLD: assert property (
        @(posedge pclk) disable iff (!presetn)
        pm_hold |=>
        $stable(port_pin_out) && $stable(port_pin_oe_n))
        else $error("pins changed while held");
    AST_RT_READ: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && hit_data && func_q[4] |=>
        prdata[4] == $past(data_q[4]))
        else $error("realtime read not data register");
    AST_GP_READ: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && hit_data && !func_q[5] &&
        !dir_q[5] |=> prdata[5] == $past(pin_level_q[5]))
        else $error("input pin read wrong");
    AST_SRC_HSW: assert property (
        @(posedge pclk) disable iff (!presetn)
        hsw_hit_q && func_q[6] && src_q[6] |=>
        cshadow_q[6] == $past(dir_q[6]))
        else $error("head-switch trigger load missed");
    AST_SHADOW_KEEP: assert property (
        @(posedge pclk) disable iff (!presetn)
        func_q[0] && !rt_load[0] |=>
        dshadow_q[0] == $past(dshadow_q[0]))
        else $error("shadow changed without trigger");
    AST_EDGE_FALL: assert property (
        @(posedge pclk) disable iff (!presetn)
        edge_q == rtp_pkg::EDGE_FALL && ext_rise |=>
        !ext_hit_q)
        else $error("rising edge taken in falling mode");
    AST_EDGE_RISE: assert property (
        @(posedge pclk) disable iff (!presetn)
        edge_q == rtp_pkg::EDGE_RISE && ext_fall |=>
        !ext_hit_q)
        else $error("falling edge taken in rising mode");
    AST_DATA_MIRROR: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_data && !func_q[4] |=>
        dshadow_q[4] == $past(wbyte[4]))
        else $error("data shadow not mirrored");
    AST_GP_INPUT: assert property (
        @(posedge pclk) disable iff (!presetn)
        !func_q[2] && !dir_q[2] && !pm_hold |=>
        port_pin_oe_n[2])
        else $error("general input pin driven");
    AST_RT_FLOAT: assert property (
        @(posedge pclk) disable iff (!presetn)
        func_q[1] && !cshadow_q[1] && !pm_hold |=>
        port_pin_oe_n[1])
        else $error("realtime pin driven while disabled");
    COV_RT_LOAD: cover property (@(posedge pclk) disable iff (!presetn)
        |rt_load);
    COV_HSW: cover property (@(posedge pclk) disable iff (!presetn)
        hsw_hit_q && |(src_q & func_q));
    COV_BOTH: cover property (@(posedge pclk) disable iff (!presetn)
        edge_q == rtp_pkg::EDGE_BOTH && ext_hit_q);
    COV_TMR: cover property (@(posedge pclk) disable iff (!presetn)
        aux_q[rtp_pkg::AUX_TMR_BIT] && timer_event_input);
    COV_HOLD: cover property (@(posedge pclk) disable iff (!presetn)
        pm_hold && wr_data);
endmodule : rtp_port

// ### core/rtp_pkg.sv
// Package with register map, field layout and reset values of the port.
package rtp_pkg;
    localparam int          PORT_W          = 8;
    localparam int          ADDR_W          = 18;
    // Register indices; the bus byte address is four times the index.
    localparam logic [15:0] ADR_DATA        = 16'hffc6;
    localparam logic [15:0] ADR_DIR         = 16'hffd6;
    localparam logic [15:0] ADR_AUX_MODE    = 16'hffd9;
    localparam logic [15:0] ADR_FUNC        = 16'hffdd;
    localparam logic [15:0] ADR_EDGE        = 16'hffe4;
    localparam logic [15:0] ADR_SRC         = 16'hffe5;
    localparam logic [15:0] ADR_POWER       = 16'hffe8;
    localparam logic [7:0]  RST_ZERO        = 8'h00;
    localparam logic [7:0]  RST_EDGE        = 8'hfc;
    localparam logic [7:0]  RST_AUX_MODE    = 8'h3f;
    localparam logic [7:0]  EDGE_FIXED_ONES = 8'hfc;
    localparam logic [7:0]  AUX_RW_MASK     = 8'hc0;
    localparam logic [7:0]  DIR_READ_VALUE  = 8'hff;
    localparam int          AUX_TMR_BIT     = 7;
    localparam int          TMR_PIN         = 7;
    localparam logic [1:0]  EDGE_OFF        = 2'h0;
    localparam logic [1:0]  EDGE_RISE       = 2'h1;
    localparam logic [1:0]  EDGE_FALL       = 2'h2;
    localparam logic [1:0]  EDGE_BOTH       = 2'h3;
    // Power mode field encoding.
    typedef enum logic [2:0] {
        RTP_PM_ACTIVE,
        RTP_PM_SLEEP,
        RTP_PM_STANDBY,
        RTP_PM_WATCH,
        RTP_PM_SUBACTIVE,
        RTP_PM_SUBSLEEP
    } rtp_pmode_t;
endpackage : rtp_pkg

// ### verification/rtp_ext_model.sv
// Model of the circuitry outside the port pins and trigger lines.
`timescale 1ns/100ps
module rtp_ext_model (
    // Clock.
    input  wire logic       pclk,
    // Device side of the pins.
    input  wire logic [7:0] port_pin_out,
    input  wire logic [7:0] port_pin_oe_n,
    output logic      [7:0] port_pin_in,
    // Levels the outside world presents.
    input  wire logic [7:0] ext_val,
    input  wire logic       ext_trig,
    input  wire logic       hsw_trig,
    output logic            external_trigger_pin,
    output logic            head_switch_timing_trigger
);
    // Trigger lines always sit at a firm level, never in between.
    always_ff @(posedge pclk) begin
        external_trigger_pin       <= ext_trig;
        head_switch_timing_trigger <= hsw_trig;
    end
    // The device wins where it drives; elsewhere the outside level shows.
    assign port_pin_in = (port_pin_out & ~port_pin_oe_n)
                       | (ext_val & port_pin_oe_n);
endmodule : rtp_ext_model

// ### verification/test_realtime_output_io_port.sv
// Self-checking bench for the realtime output port.
`timescale 1ns/100ps
module test_realtime_output_io_port;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [rtp_pkg::ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, err_q, ext_line, hsw_line, tmr;
    logic [7:0]  pin_in, pin_out, oe_n, ed, eo;
    logic [7:0]  ext_val = 8'h00;
    logic        ext_trig = 1'b0;
    logic        hsw_trig = 1'b0;
    int          num_errors = 0;
    int          samples_checked = 0;
    always #25 pclk = ~pclk;
    rtp_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_pin_in(pin_in), .port_pin_out(pin_out), .port_pin_oe_n(oe_n),
        .external_trigger_pin(ext_line),
        .head_switch_timing_trigger(hsw_line), .timer_event_input(tmr));
    rtp_ext_model i_ext (.pclk(pclk), .port_pin_out(pin_out),
        .port_pin_oe_n(oe_n), .port_pin_in(pin_in), .ext_val(ext_val),
        .ext_trig(ext_trig), .hsw_trig(hsw_trig),
        .external_trigger_pin(ext_line),
        .head_switch_timing_trigger(hsw_line));
    task automatic chk(input string nm, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [7:0] d, output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        // The byte address is four times the register index.
        paddr <= {a, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Hold the request until the slave answers; the watchdog ends a hang.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        logic [31:0] r;
        apb(1'b0, a, 8'h00, r);
        chk("prdata", r, {24'h0, e});
    endtask : rd
    // Waits out pin flops and input synchronisers before looking.
    task automatic pins(input logic [7:0] o, oe);
        repeat (8) @(posedge pclk);
        chk("pin_oe_n", oe_n, oe);
        chk("pin_out", pin_out & ~oe_n, o & ~oe);
    endtask : pins
    task automatic trig(input logic e, h);
        @(posedge pclk);
        ext_trig <= e;
        hsw_trig <= h;
    endtask : trig
    task automatic t_reset();
        rd(rtp_pkg::ADR_EDGE, 8'hfc);
        rd(rtp_pkg::ADR_SRC, 8'h00);
        rd(rtp_pkg::ADR_DIR, 8'hff);
        rd(rtp_pkg::ADR_DATA, 8'h00);
        rd(16'hffe0, 8'h00);
        chk("pslverr", err_q, 1'b1);
        wr(rtp_pkg::ADR_EDGE, 8'hff);
        rd(rtp_pkg::ADR_EDGE, 8'hff);
    endtask : t_reset
    task automatic t_gen();
        wr(rtp_pkg::ADR_DIR, 8'h0f);
        wr(rtp_pkg::ADR_DATA, 8'ha5);
        @(posedge pclk);
        ext_val <= 8'h3c;
        pins(8'h05, 8'hf0);
        rd(rtp_pkg::ADR_DATA, 8'h35);
    endtask : t_gen
    task automatic t_rt();
        logic [7:0] v;
        ed = 8'h05;
        eo = 8'hf0;
        wr(rtp_pkg::ADR_FUNC, 8'hff);
        wr(rtp_pkg::ADR_DIR, 8'hff);
        pins(ed, eo);
        for (int m = 0; m < 4; m++) begin
            v = {4'(m), 4'h9};
            wr(rtp_pkg::ADR_EDGE, {6'h0, m[1:0]});
            wr(rtp_pkg::ADR_DATA, v);
            trig(1'b1, 1'b0);
            ed = m[0] ? v : ed;
            eo = m[0] ? 8'h00 : eo;
            pins(ed, eo);
            wr(rtp_pkg::ADR_DATA, ~v);
            trig(1'b0, 1'b0);
            ed = m[1] ? ~v : ed;
            eo = m[1] ? 8'h00 : eo;
            pins(ed, eo);
            rd(rtp_pkg::ADR_DATA, ~v);
        end
    endtask : t_rt
    task automatic t_src();
        wr(rtp_pkg::ADR_SRC, 8'hff);
        wr(rtp_pkg::ADR_DATA, 8'h3c);
        trig(1'b1, 1'b0);
        pins(ed, eo);
        trig(1'b1, 1'b1);
        pins(8'h3c, 8'h00);
        wr(rtp_pkg::ADR_DIR, 8'h00);
        trig(1'b1, 1'b0);
        pins(8'h00, 8'hff);
        rd(rtp_pkg::ADR_DIR, 8'hff);
    endtask : t_src
    task automatic t_tmr();
        wr(rtp_pkg::ADR_FUNC, 8'h00);
        wr(rtp_pkg::ADR_AUX_MODE, 8'h80);
        rd(rtp_pkg::ADR_AUX_MODE, 8'hbf);
        @(posedge pclk);
        ext_val <= 8'h80;
        pins(8'h00, 8'hff);
        chk("timer_event_input", tmr, 1'b1);
        rd(rtp_pkg::ADR_DATA, 8'h80);
        wr(rtp_pkg::ADR_DIR, 8'h80);
        pins(8'h00, 8'hff);
        rd(rtp_pkg::ADR_DATA, 8'h00);
        wr(rtp_pkg::ADR_AUX_MODE, 8'h00);
    endtask : t_tmr
    task automatic t_pwr();
        wr(rtp_pkg::ADR_DIR, 8'hff);
        wr(rtp_pkg::ADR_DATA, 8'h5a);
        pins(8'h5a, 8'h00);
        wr(rtp_pkg::ADR_POWER, 8'h01);
        wr(rtp_pkg::ADR_DATA, 8'ha5);
        pins(8'h5a, 8'h00);
        wr(rtp_pkg::ADR_POWER, 8'h04);
        pins(8'ha5, 8'h00);
        wr(rtp_pkg::ADR_POWER, 8'h05);
        wr(rtp_pkg::ADR_DATA, 8'h5a);
        pins(8'ha5, 8'h00);
        wr(rtp_pkg::ADR_POWER, 8'h02);
        pins(8'h00, 8'hff);
        wr(rtp_pkg::ADR_POWER, 8'h03);
        pins(8'h00, 8'hff);
        wr(rtp_pkg::ADR_POWER, 8'h00);
        pins(8'h5a, 8'h00);
    endtask : t_pwr
    task automatic summarize();
        if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize
    // Far beyond the few hundred cycles the scenarios need.
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge pclk);
        chk("pin_oe_n", oe_n, 8'hff);
        presetn <= 1'b1;
        t_reset();
        t_gen();
        t_rt();
        t_src();
        t_tmr();
        t_pwr();
        summarize();
    end
endmodule : test_realtime_output_io_port
